// *** include/dma_arb_consts.svh ***
// register offsets, reset values and timing counts of the dma arbiter
`ifndef DMA_ARB_CONSTS_SVH
`define DMA_ARB_CONSTS_SVH
`define OFS_OPR 8'h00
`define OFS_CH0 8'h04
`define OFS_CH3 8'h10
`define OFS_STAT 8'h14
`define OPR_RST 8'h00
`define CCR_RST 10'h000
`define ORD_RST 8'he4
`define ORD_FIX1 8'he4
`define ORD_FIX2 8'h78
`define GAP16_CLK 7'd16
`define GAP64_CLK 7'd64
`endif

// *** include/dma_arb_pkg.sv ***
// types shared by the dma arbiter and its users
package dma_arb_pkg;
    typedef enum logic [1:0] {PRI_FIX1, PRI_FIX2, PRI_RR_SEL, PRI_RR_ALL}
        pri_mode_t;
    typedef enum logic [1:0] {GAP_NONE, GAP_16, GAP_64, GAP_RSVD}
        gap_mode_t;
    typedef enum logic [1:0] {SRC_AUTO, SRC_EXT, SRC_PERIPH, SRC_RSVD}
        req_src_t;
    typedef enum logic [1:0] {UNIT_B, UNIT_W, UNIT_L, UNIT_16B} unit_t;
    // channel control register, bit 0 first from the right
    typedef struct packed {
        logic sgl_dir;
        unit_t size;
        logic periph;
        req_src_t src;
        logic single;
        logic ack_cycle_select;
        logic bus_mode_select;
        logic en;
    } ch_ctrl_t;
    // operation register
    typedef struct packed {
        gap_mode_t gap;
        logic [3:0] rotation_channel_select;
        logic priority_mode_bit_high;
        logic priority_mode_bit_low;
    } opr_t;
    // one transfer bus cycle towards the system bus
    typedef struct packed {
        logic cyc;
        logic we;
        logic [1:0] chan;
    } xfer_t;
endpackage

// *** rtl/dma_arb.sv ***
// dma channel arbiter and transfer sequencer with wishbone registers
// Operation
// [RL1] grant exactly one channel by priority
// [RL2] four priority modes from operation register
// [RL3] fixed one: 0 over 1 over 2 over 3
// [RL4] fixed two: 0, 2, 3, then 1
// [RL5] round robin rotates after every unit (selected mode: only units of rotation_channel_select channels)
// [RL6] finished channel drops last, rest shift up
// [RL7] round robin order resets to 0,1,2,3
// [RL8] software avoids mixing modes under round robin
// [RL9] waiting request granted by updated order
// [RL10] single address only strobe device to memory
// [RL11] single address starts from request pin only
// [RL12] peripheral transfers never use 16-byte units
// [RL13] dual address reads, buffers, then writes
// [RL14] dual allows all triggers; ack cycle selectable
// [RL15] single address unit in one bus cycle
// [RL16] per channel cycle steal or burst
// [RL17] cycle steal releases bus after each unit
// [RL18] intermittent waits 16 or 64 clocks
// [RL19] software uses intermittent with cycle steal only
// [RL20] intermittent defers during cache refill
// [RL21] burst keeps bus until no request remains
// [RL22] request pin ignored until acknowledge issued
// [RL23] request bus, start after grant, release
//
// The Wishbone slave port and the register offsets were left to the implementer.
`include "dma_arb_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dma_arb (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // request sources
    input wire logic [1:0] transfer_request_n_i,
    input wire logic [3:0] periph_req_i,
    // system bus ownership
    output logic bus_req_o,
    input wire logic bus_grant_i,
    input wire logic refill_busy_i,
    // transfer bus cycles
    output dma_arb_pkg::xfer_t xfer_o,
    input wire logic cyc_ack_i,
    input wire logic [31:0] rd_data_i,
    output logic [31:0] wr_data_o,
    output logic [1:0] transfer_acknowledge_n_o
);
    typedef enum logic [3:0] {S_IDLE, S_GAP, S_BREQ, S_DEFER, S_RD, S_WR,
        S_SGL, S_END, S_PICK} state_t;

    function automatic logic [2:0] pick(input logic [3:0] r,
        input logic [7:0] o);
        logic [2:0] w;
        w = 3'h0;
        for (int i = 3; i >= 0; i--)
        begin
            if (r[o[2*i+:2]])
            begin
                w = {1'b1, o[2*i+:2]};
            end
        end
        return w;
    endfunction

    function automatic logic [7:0] rotate(input logic [7:0] o,
        input logic [1:0] c);
        logic [7:0] r;
        logic [1:0] k;
        r = 8'h00;
        k = 2'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (o[2*i+:2] != c)
            begin
                r[2*k+:2] = o[2*i+:2];
                k = k + 2'h1;
            end
        end
        r[7:6] = c;
        return r;
    endfunction

    function automatic logic [31:0] lanes(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                r[8*b+:8] = d[8*b+:8];
            end
        end
        return r;
    endfunction

    state_t state_reg, state_next;
    dma_arb_pkg::opr_t opr_reg;
    dma_arb_pkg::ch_ctrl_t ccr_reg [4];
    dma_arb_pkg::xfer_t xfer_next;
    logic [7:0] ord_reg, ord_next;
    logic [1:0] chan_reg, chan_next;
    logic [6:0] gap_cnt_reg;
    logic gap_due_reg;
    logic [1:0] ext_s1_reg, ext_s2_reg;
    logic [1:0] ext_mask_reg;
    logic [3:0] err_reg;
    logic [31:0] hold_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [1:0] transfer_acknowledge_n_n_reg;

    // register decode
    wire wb_hit = cyc_i && stb_i && !ack_reg;
    wire wb_wr = wb_hit && we_i;
    wire opr_sel = adr_i == `OFS_OPR;
    wire ch_sel = adr_i >= `OFS_CH0 && adr_i <= `OFS_CH3 &&
        adr_i[1:0] == 2'h0;
    wire [1:0] ch_idx = 2'(adr_i[3:2] - 2'h1);
    wire stat_sel = adr_i == `OFS_STAT;
    wire [31:0] opr_wval = lanes({24'h0, opr_reg}, dat_i, sel_i);
    wire [31:0] ccr_wval = lanes({22'h0, ccr_reg[ch_idx]}, dat_i, sel_i);

    // priority mode and effective order
    wire [1:0] pri_bits = {opr_reg.priority_mode_bit_high,
        opr_reg.priority_mode_bit_low};
    wire dma_arb_pkg::pri_mode_t pri = dma_arb_pkg::pri_mode_t'(pri_bits);
    wire rr_mode = pri == dma_arb_pkg::PRI_RR_SEL ||
        pri == dma_arb_pkg::PRI_RR_ALL;
    wire [7:0] eff_ord = pri == dma_arb_pkg::PRI_FIX1 ? `ORD_FIX1 : // [RL3]
        pri == dma_arb_pkg::PRI_FIX2 ? `ORD_FIX2 : ord_reg; // [RL2] [RL4]
    wire gap_on = opr_reg.gap == dma_arb_pkg::GAP_16 ||
        opr_reg.gap == dma_arb_pkg::GAP_64;
    wire [6:0] gap_len = opr_reg.gap == dma_arb_pkg::GAP_64 ?
        `GAP64_CLK : `GAP16_CLK;

    // per channel validity and trigger
    logic [3:0] valid, trig, req, burst_vec;
    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            // strobed device only with external memory side
            valid[c] = !(ccr_reg[c].single &&
                (ccr_reg[c].periph || c > 1)); // [RL10]
            if (ccr_reg[c].single &&
                ccr_reg[c].src != dma_arb_pkg::SRC_EXT)
            begin
                valid[c] = 1'b0; // [RL11]
            end
            if (ccr_reg[c].periph &&
                ccr_reg[c].size == dma_arb_pkg::UNIT_16B)
            begin
                valid[c] = 1'b0; // [RL12]
            end
            unique case (ccr_reg[c].src) // [RL14]
                dma_arb_pkg::SRC_AUTO: trig[c] = 1'b1;
                dma_arb_pkg::SRC_EXT: trig[c] = c < 2 &&
                    ext_s2_reg[c[0]] && !ext_mask_reg[c[0]]; // [RL22]
                dma_arb_pkg::SRC_PERIPH: trig[c] = periph_req_i[c];
                default: trig[c] = 1'b0;
            endcase
            req[c] = ccr_reg[c].en && valid[c] && trig[c];
            burst_vec[c] = ccr_reg[c].bus_mode_select; // [RL16]
        end
    end

    wire [2:0] win = pick(req, eff_ord); // [RL1] [RL9]
    wire any_req = win[2];
    wire keep_bus = |(req & burst_vec); // [RL21]
    wire dma_arb_pkg::ch_ctrl_t cur = ccr_reg[chan_reg];
    wire dma_arb_pkg::ch_ctrl_t nxt_cc = ccr_reg[win[1:0]];
    wire start_ok = !(gap_on && refill_busy_i); // [RL20]
    wire [2:0] start_st = nxt_cc.single ? 3'd1 : 3'd0;
    wire rot_ok = pri == dma_arb_pkg::PRI_RR_ALL ||
        opr_reg.rotation_channel_select[chan_reg];

    // sequencer
    always_comb
    begin
        state_next = state_reg;
        chan_next = chan_reg;
        ord_next = ord_reg;
        unique case (state_reg)
            S_IDLE:
                if (any_req)
                begin
                    state_next = gap_on && gap_due_reg ? S_GAP : S_BREQ;
                end
            S_GAP:
                if (gap_cnt_reg == gap_len - 7'd1)
                begin
                    state_next = S_BREQ; // [RL18]
                end
            S_BREQ, S_PICK:
                if (state_reg == S_PICK || bus_grant_i) // [RL23]
                begin
                    if (!any_req)
                    begin
                        state_next = S_IDLE;
                    end
                    else
                    begin
                        chan_next = win[1:0];
                        if (!start_ok)
                        begin
                            state_next = S_DEFER;
                        end
                        else
                        begin
                            state_next = start_st[0] ? S_SGL : S_RD;
                        end
                    end
                end
            S_DEFER:
                if (!refill_busy_i)
                begin
                    state_next = cur.single ? S_SGL : S_RD;
                end
            S_RD:
                if (cyc_ack_i)
                begin
                    state_next = S_WR; // [RL13]
                end
            S_WR, S_SGL:
                if (cyc_ack_i)
                begin
                    state_next = S_END; // [RL15]
                end
            S_END:
            begin
                if (rr_mode && rot_ok)
                begin
                    ord_next = rotate(ord_reg, chan_reg); // [RL5] [RL6]
                end
                // cycle steal gives the bus back after every unit while no burst channel requests
                state_next = keep_bus ? S_PICK : S_IDLE; // [RL17] [RL21]
            end
        endcase
    end

    // bus cycle outputs decoded from the next state
    wire rd_cyc = state_next == S_RD;
    wire wr_cyc = state_next == S_WR;
    wire sg_cyc = state_next == S_SGL;
    wire dma_arb_pkg::ch_ctrl_t cc_n = ccr_reg[chan_next];
    wire transfer_acknowledge_n_on = sg_cyc || (cc_n.ack_cycle_select ? wr_cyc : rd_cyc);
    always_comb
    begin
        xfer_next.cyc = rd_cyc || wr_cyc || sg_cyc;
        xfer_next.we = wr_cyc || (sg_cyc && cc_n.sgl_dir);
        xfer_next.chan = chan_next;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= S_IDLE;
            chan_reg <= 2'h0;
            ord_reg <= `ORD_RST; // [RL7]
            xfer_o <= '0;
            transfer_acknowledge_n_n_reg <= 2'h3;
        end
        else
        begin
            state_reg <= state_next;
            chan_reg <= chan_next;
            ord_reg <= ord_next;
            xfer_o <= xfer_next;
            transfer_acknowledge_n_n_reg <= 2'h3;
            if (transfer_acknowledge_n_on && chan_next < 2'h2 &&
                cc_n.src == dma_arb_pkg::SRC_EXT)
            begin
                transfer_acknowledge_n_n_reg[chan_next[0]] <= 1'b0; // [RL14] [RL15]
            end
        end
    end

    // gap counter and the flag that a release has happened
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gap_cnt_reg <= 7'h00;
            gap_due_reg <= 1'b0;
        end
        else
        begin
            gap_cnt_reg <= state_reg == S_GAP ? gap_cnt_reg + 7'd1 : 7'h00;
            if (state_reg == S_END && !keep_bus)
            begin
                gap_due_reg <= 1'b1;
            end
            else if (state_reg == S_GAP)
            begin
                gap_due_reg <= 1'b0;
            end
        end
    end

    // request pin: two-flop sync, active low level, masked while accepted
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_s1_reg <= 2'h0;
            ext_s2_reg <= 2'h0;
            ext_mask_reg <= 2'h0;
        end
        else
        begin
            ext_s1_reg <= ~transfer_request_n_i;
            ext_s2_reg <= ext_s1_reg;
            for (int c = 0; c < 2; c++)
            begin
                if (state_reg == S_END && chan_reg == 2'(c))
                begin
                    ext_mask_reg[c] <= 1'b0; // [RL22]
                end
                if (chan_next == 2'(c) && state_next != state_reg &&
                    (state_next == S_RD || state_next == S_SGL ||
                    state_next == S_DEFER) &&
                    cc_n.src == dma_arb_pkg::SRC_EXT &&
                    state_reg != S_DEFER)
                begin
                    ext_mask_reg[c] <= 1'b1; // [RL22]
                end
            end
        end
    end

    // read data holding buffer for dual address transfers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hold_reg <= 32'h0;
        end
        else if (state_reg == S_RD && cyc_ack_i)
        begin
            hold_reg <= rd_data_i; // [RL13]
        end
    end

    // wishbone registers; a bad setting sets a sticky error bit
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            opr_reg <= `OPR_RST;
            for (int c = 0; c < 4; c++)
            begin
                ccr_reg[c] <= `CCR_RST;
            end
            err_reg <= 4'h0;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end
        else
        begin
            ack_reg <= wb_hit;
            if (wb_wr && opr_sel)
            begin
                opr_reg <= opr_wval[7:0];
            end
            if (wb_wr && ch_sel)
            begin
                ccr_reg[ch_idx] <= ccr_wval[9:0];
                err_reg[ch_idx] <= 1'b0;
            end
            // set wins over the clear by a write
            for (int c = 0; c < 4; c++)
            begin
                if (ccr_reg[c].en && !valid[c])
                begin
                    err_reg[c] <= 1'b1;
                end
            end
            if (opr_sel)
            begin
                dat_reg <= {24'h0, opr_reg};
            end
            else if (ch_sel)
            begin
                dat_reg <= {22'h0, ccr_reg[ch_idx]};
            end
            else if (stat_sel)
            begin
                dat_reg <= {14'h0, xfer_o.cyc, bus_req_o, err_reg,
                    2'h0, chan_reg, ord_reg};
            end
            else
            begin
                dat_reg <= 32'h0;
            end
        end
    end

    assign bus_req_o = state_reg == S_BREQ || state_reg == S_DEFER ||
        state_reg == S_RD || state_reg == S_WR || state_reg == S_SGL ||
        state_reg == S_END || state_reg == S_PICK; // [RL23]
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
    assign wr_data_o = hold_reg;
    assign transfer_acknowledge_n_o = transfer_acknowledge_n_n_reg;

    // checks
    fix1_grant_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
        state_reg == S_BREQ && bus_grant_i && req[0] &&
        pri == dma_arb_pkg::PRI_FIX1 |=> chan_reg == 2'h0)
        else $error("fixed one did not grant channel 0");
    fix2_order_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
        (state_reg == S_PICK || (state_reg == S_BREQ && bus_grant_i)) &&
        req[2] && !req[0] && start_ok &&
        pri == dma_arb_pkg::PRI_FIX2 |=> chan_reg == 2'h2)
        else $error("fixed two did not rank channel 2 second");
    grant_needs_req_a: assert property (@(posedge clk_i) // [RL1]
        disable iff (rst_i)
        state_reg == S_PICK && !any_req |=> state_reg == S_IDLE)
        else $error("grant without a pending request");
    rr_rotate_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
        state_reg == S_END && pri == dma_arb_pkg::PRI_RR_ALL
        |=> ord_reg[7:6] == $past(chan_reg))
        else $error("finished channel not moved to lowest");
    order_reset_a: assert property (@(posedge clk_i) // [RL7]
        $past(rst_i) |-> ord_reg == `ORD_RST)
        else $error("round robin order wrong after reset");
    dual_two_cyc_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL13]
        state_reg == S_RD && cyc_ack_i |=> xfer_o.cyc && xfer_o.we &&
        wr_data_o == $past(rd_data_i))
        else $error("write cycle missing after read");
    single_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL15]
        state_reg == S_SGL && cyc_ack_i |=> !xfer_o.cyc ##1 !xfer_o.cyc)
        else $error("single address took more than one cycle");
    steal_release_a: assert property (@(posedge clk_i) // [RL17]
        disable iff (rst_i)
        state_reg == S_END && !keep_bus |=> !bus_req_o)
        else $error("bus kept after cycle steal unit");
    gap_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL18]
        state_reg == S_GAP && $past(state_reg) != S_GAP
        |-> state_reg == S_GAP [*8])
        else $error("intermittent gap ended early");
    pin_mask_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL22]
        ext_mask_reg[0] && ccr_reg[0].src == dma_arb_pkg::SRC_EXT
        |-> !req[0])
        else $error("request pin taken while masked");
    cyc_owned_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL23]
        xfer_o.cyc |-> bus_req_o)
        else $error("bus cycle without bus ownership");
    bad_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL12]
        ccr_reg[2].periph && ccr_reg[2].size == dma_arb_pkg::UNIT_16B
        |-> !req[2])
        else $error("peripheral request with 16-byte unit");
endmodule
`default_nettype wire

// *** tb/bus_partner.sv ***
// system bus arbiter and memory model facing the dma transfer port
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // cycles waited before grant and before each ack
    input wire logic [3:0] pace_i,
    // dma side
    input wire logic bus_req_i,
    input wire dma_arb_pkg::xfer_t xfer_i,
    output logic bus_grant_o,
    output logic cyc_ack_o,
    output logic [31:0] rd_data_o
);
    logic [3:0] cnt_reg;
    logic [31:0] pat_reg;
    logic idle;
    logic ripe;
    assign idle = !(bus_req_i || xfer_i.cyc);
    assign ripe = cnt_reg >= pace_i;
    // data outside the ack cycle is inverted so a late sample shows
    assign rd_data_o = cyc_ack_o ? pat_reg : ~pat_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || cyc_ack_o || idle)
            cnt_reg <= 4'h0;
        else if (cnt_reg != 4'hf)
            cnt_reg <= cnt_reg + 4'h1;
    end
    always_ff @(posedge clk_i)
    begin
        pat_reg <= rst_i ? 32'h1357_9bdf : {pat_reg[30:0], ~pat_reg[31]};
    end
    // grant only while requested, withdrawn once the request drops
    always_ff @(posedge clk_i)
    begin
        bus_grant_o <= !rst_i && bus_req_i && ripe;
        cyc_ack_o <= !rst_i && xfer_i.cyc && !cyc_ack_o && ripe;
    end
endmodule
`default_nettype wire

// *** tb/dma_channel_arbiter_bus_modes_test.sv ***
// self-checking bench for the dma channel arbiter
`timescale 1ns/1ps
`default_nettype none
`include "dma_arb_consts.svh"
module dma_channel_arbiter_bus_modes_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wstb = 1'b0;
    logic wwe = 1'b0;
    logic [7:0] wadr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [1:0] pin_n = 2'b11;
    logic [3:0] preq = 4'h0;
    logic refill = 1'b0;
    logic [3:0] pace = 4'h0;
    logic [31:0] rdat, rd, wr_data, last_rd;
    logic ack, breq, grant, cack, breq_d = 1'b0, dual_on = 1'b1, last_we;
    logic [1:0] transfer_acknowledge_n, rd_transfer_acknowledge_n, wr_transfer_acknowledge_n, last_transfer_acknowledge_n;
    logic [1:0] seen[$];
    dma_arb_pkg::xfer_t xfer;
    int mismatches = 0, n_tests = 0, units = 0, falls = 0, rises = 0;
    int low_run = 0, gap_len = 0;
    always #5 clk = ~clk;
    dma_arb dut (.clk_i(clk), .rst_i(rst), .cyc_i(wstb), .stb_i(wstb),
        .we_i(wwe), .adr_i(wadr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .transfer_request_n_i(pin_n), .periph_req_i(preq),
        .bus_req_o(breq), .bus_grant_i(grant), .refill_busy_i(refill),
        .xfer_o(xfer), .cyc_ack_i(cack), .rd_data_i(rd),
        .wr_data_o(wr_data), .transfer_acknowledge_n_o(transfer_acknowledge_n));
    bus_partner far_side (.clk_i(clk), .rst_i(rst), .pace_i(pace),
        .bus_req_i(breq), .xfer_i(xfer), .bus_grant_o(grant),
        .cyc_ack_o(cack), .rd_data_o(rd));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang();
        mismatches++;
        $display("MISMATCH wait expected done seen timeout");
        print_verdict();
    endtask
    // watches sampled values at each edge, so no race with the design
    always @(posedge clk)
    begin
        // take the low run before it is cleared by the rising request
        if (!breq_d && breq)
            gap_len = low_run;
        low_run = breq ? 0 : low_run + 1;
        if (breq_d && !breq)
            falls++;
        if (!breq_d && breq)
            rises++;
        breq_d = breq;
        if (xfer.cyc && cack)
        begin
            units++;
            last_we = xfer.we;
            last_transfer_acknowledge_n = transfer_acknowledge_n;
            if (!xfer.we)
            begin
                seen.push_back(xfer.chan);
                last_rd = rd;
                rd_transfer_acknowledge_n = transfer_acknowledge_n;
            end
            else if (dual_on)
            begin
                wr_transfer_acknowledge_n = transfer_acknowledge_n;
                cmp("hold_data", last_rd, wr_data);
            end
        end
    end
    task automatic wait_cnt(ref int v, input int k);
        int n;
        n = 0;
        while (v < k && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000)
            hang();
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wstb <= 1'b1;
        wwe <= w;
        wadr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            hang();
        q = rdat;
        wstb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        preq <= 4'h0;
        pin_n <= 2'b11;
        refill <= 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        seen.delete();
        units = 0;
        falls = 0;
        rises = 0;
    endtask
    task automatic reg_basic();
        logic [31:0] q;
        do_reset();
        wb(1'b0, `OFS_STAT, 32'h0, q);
        cmp("order_rst", 32'he4, q & 32'hff);
        wb(1'b0, `OFS_OPR, 32'h0, q);
        cmp("opr_rst", 32'h0, q);
        wb(1'b1, 8'h20, 32'hffff_ffff, q);
        wb(1'b0, 8'h20, 32'h0, q);
        cmp("unmapped", 32'h0, q);
    endtask
    // all channels cycle steal, so round robin never mixes bus modes
    task automatic prio_modes();
        logic [31:0] q;
        logic [1:0] exp_ch[4][3] = '{'{1, 1, 1}, '{2, 2, 2}, '{0, 1, 1},
            '{0, 3, 0}};
        logic [3:0] req_t[4] = '{4'he, 4'he, 4'h3, 4'h9};
        for (int m = 0; m < 4; m++)
        begin
            do_reset();
            wb(1'b1, `OFS_OPR, 32'h4 | m, q);
            for (int c = 0; c < 4; c++)
                wb(1'b1, `OFS_CH0 + 8'(4 * c), 32'h21, q);
            preq <= req_t[m];
            wait_cnt(units, 6);
            preq <= 4'h0;
            for (int i = 0; i < 3; i++)
                cmp("grant_ch", exp_ch[m][i], seen[i]);
        end
    endtask
    task automatic dual_ack();
        logic [31:0] q;
        pace <= 4'h3;
        for (int s = 0; s < 2; s++)
        begin
            do_reset();
            wb(1'b1, `OFS_CH0, 32'h11 | (s << 2), q);
            pin_n <= 2'b10;
            wait_cnt(units, 4);
            pin_n <= 2'b11;
            cmp("rd_transfer_acknowledge_n", s ? 2'b11 : 2'b10, rd_transfer_acknowledge_n);
            cmp("wr_transfer_acknowledge_n", s ? 2'b10 : 2'b11, wr_transfer_acknowledge_n);
        end
        pace <= 4'h0;
    endtask
    task automatic single_mode();
        logic [31:0] q;
        logic [31:0] bad[4] = '{32'h9, 32'h29, 32'h59, 32'h1c1};
        int hi;
        for (int i = 0; i < 4; i++)
        begin
            do_reset();
            hi = 0;
            wb(1'b1, `OFS_CH0, bad[i], q);
            preq <= 4'h1;
            pin_n <= 2'b10;
            repeat (30)
            begin
                @(posedge clk);
                hi += breq;
            end
            cmp("no_req", 32'h0, hi);
            wb(1'b0, `OFS_STAT, 32'h0, q);
            cmp("err_bit", 32'h1, q[12]);
        end
        do_reset();
        dual_on = 1'b0;
        wb(1'b1, `OFS_CH0, 32'h219, q);
        pin_n <= 2'b10;
        wait_cnt(falls, 1);
        pin_n <= 2'b11;
        cmp("sgl_cycles", 32'h1, units);
        cmp("sgl_we", 32'h1, last_we);
        cmp("sgl_transfer_acknowledge_n", 2'b10, last_transfer_acknowledge_n);
        dual_on = 1'b1;
    endtask
    task automatic bus_modes();
        logic [31:0] q;
        for (int b = 0; b < 2; b++)
        begin
            do_reset();
            pace <= 4'(2 * b);
            wb(1'b1, `OFS_CH0, 32'h1 | (b << 1), q);
            wait_cnt(units, 6);
            cmp("released", !b, falls >= 2);
            cmp("bus_kept", b, falls == 0);
        end
        pace <= 4'h0;
    endtask
    // intermittent gaps only ever run with cycle steal channels
    task automatic gap_modes();
        logic [31:0] q;
        int n, hi;
        for (int g = 1; g < 3; g++)
        begin
            do_reset();
            n = (g == 1) ? 16 : 64;
            hi = 0;
            wb(1'b1, `OFS_OPR, 32'(g << 6), q);
            wb(1'b1, `OFS_CH0, 32'h1, q);
            wait_cnt(falls, 1);
            refill <= 1'b1;
            // the first rise belongs to the unit before the gap
            wait_cnt(rises, 2);
            cmp("gap_len", 32'h1, gap_len >= n && gap_len <= n + 2);
            n = units;
            repeat (10)
            begin
                @(posedge clk);
                hi += xfer.cyc;
            end
            cmp("defer", 32'h0, hi);
            refill <= 1'b0;
            wait_cnt(units, n + 1);
        end
    endtask
    initial
    begin
        reg_basic();
        prio_modes();
        dual_ack();
        single_mode();
        bus_modes();
        gap_modes();
        print_verdict();
    end
endmodule
`default_nettype wire
